// >>> design/converter_on_off_sequencer.sv
// enable gating, on/off delays, reference code and voltage telemetry
`timescale 1ns/1ns
`include "seq_params.svh"
module converter_on_off_sequencer
	import seq_pkg::*;
#(
	parameter int CYC_PER_MS = `CYC_PER_MS
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_rd_code,
	output logic [15:0] cmd_rdata,
	output logic cmd_rvalid,
	input wire logic [15:0] vin_meas,
	input wire logic control_enable_pin,
	input wire logic vout_smp_valid,
	input wire logic [15:0] vout_smp,
	output logic regulate,
	output logic [15:0] dac_code,
	output logic vin_ok
);
	// ****************************************************************
	// settings
	// ****************************************************************
	function automatic word_t clamp(input word_t v, input word_t lo,
		input word_t hi);
		word_t r;
		r = v;
		if (v < lo)
			r = lo;
		if (v > hi)
			r = hi;
		return r;
	endfunction : clamp

	logic [7:0] op_r;
	logic [7:0] cfg_r;
	word_t on_th_r;
	word_t off_th_r;
	word_t vout_set_r;
	word_t ton_r;
	word_t toff_r;

	wire logic wr_op = cmd_wr && cmd_code == `CMD_OPERATION;
	wire logic wr_cfg = cmd_wr && cmd_code == `CMD_ON_OFF_CFG;
	wire logic wr_von = cmd_wr && cmd_code == `CMD_INPUT_TURN_ON_THRESHOLD;
	wire logic wr_voff = cmd_wr && cmd_code == `CMD_INPUT_TURN_OFF_THRESHOLD;
	wire logic wr_vset = cmd_wr && cmd_code == `CMD_VOUT_SET;
	wire logic wr_ton = cmd_wr && cmd_code == `CMD_TURN_ON_DELAY;
	wire logic wr_toff = cmd_wr && cmd_code == `CMD_TURN_OFF_DELAY;

	// out-of-range writes saturate rather than being refused, so the
	// stored value is always one the hardware can act on
	wire word_t von_nxt = clamp(cmd_wdata, 16'h0000, `ON_TH_MAX);
	wire word_t voff_nxt = clamp(cmd_wdata, `OFF_TH_MIN, 16'hFFFF);
	wire word_t vset_nxt = clamp(cmd_wdata, `DAC_MIN, `DAC_MAX);
	wire word_t dly_nxt = clamp(cmd_wdata, 16'h0000, `DELAY_MAX_MS);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			op_r <= `RST_OPERATION;
			cfg_r <= `RST_ON_OFF_CFG;
			on_th_r <= `RST_ON_TH;
			off_th_r <= `RST_OFF_TH;
			vout_set_r <= `RST_VOUT_SET;
			ton_r <= `RST_DELAY;
			toff_r <= `RST_DELAY;
		end
		else
		begin
			if (wr_op)
				op_r <= cmd_wdata[7:0];
			if (wr_cfg)
				cfg_r <= cmd_wdata[7:0];
			if (wr_von)
				on_th_r <= von_nxt;
			if (wr_voff)
				off_th_r <= voff_nxt;
			if (wr_vset)
				vout_set_r <= vset_nxt;
			if (wr_ton)
				ton_r <= dly_nxt;
			if (wr_toff)
				toff_r <= dly_nxt;
		end
	end

	// ****************************************************************
	// undervoltage lockout with hysteresis
	// ****************************************************************
	logic vin_ok_r;
	wire logic vin_fall = vin_meas < off_th_r;
	// a turn-on setting below turn-off would otherwise chatter every edge
	wire logic vin_rise = vin_meas >= on_th_r && !vin_fall;

	always_ff @(posedge clk)
	begin
		if (rst)
			vin_ok_r <= 1'b0;
		else if (!vin_ok_r && vin_rise)
			vin_ok_r <= 1'b1;
		else if (vin_ok_r && vin_fall)
			vin_ok_r <= 1'b0;
	end

	// ****************************************************************
	// gating condition
	// ****************************************************************
	wire logic pin_term = !cfg_r[`CFG_USE_PIN_BIT] || control_enable_pin;
	wire logic cmd_term = !cfg_r[`CFG_USE_CMD_BIT] || op_r[`OP_ON_BIT];
	wire logic gate = vin_ok_r && pin_term && cmd_term;

	// ****************************************************************
	// delay timer and sequencing
	// ****************************************************************
	localparam int PW = $clog2(CYC_PER_MS + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

	seq_state_e st_r;
	seq_state_e st_nxt;
	logic [PW-1:0] pre_r;
	word_t ms_r;
	wire logic tick = pre_r == PRE_LAST;
	wire logic on_done = ms_r >= ton_r;
	wire logic off_done = ms_r >= toff_r;
	wire logic clr_tmr = st_nxt != st_r;

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			// the timer runs free in off and run, so its count is stale
			// there: only a zero delay, or undervoltage in run, may skip the wait states
			ST_OFF:
				if (gate)
					st_nxt = (ton_r == 16'h0000) ? ST_RUN : ST_ON_WAIT;
			ST_ON_WAIT:
				if (!gate)
					st_nxt = ST_OFF;
				else if (on_done)
					st_nxt = ST_RUN;
			ST_RUN:
				if (!vin_ok_r)
					st_nxt = ST_OFF;
				else if (!gate)
					st_nxt = (toff_r == 16'h0000) ? ST_OFF : ST_OFF_WAIT;
			ST_OFF_WAIT:
				if (!vin_ok_r)
					st_nxt = ST_OFF;
				else if (gate)
					st_nxt = ST_RUN;
				else if (off_done)
					st_nxt = ST_OFF;
			default:
				st_nxt = ST_OFF;
		endcase
	end

	// the timer restarts on every state change so each wait is measured
	// from the moment the gating condition moved
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_r <= ST_OFF;
			pre_r <= '0;
			ms_r <= 16'h0000;
		end
		else
		begin
			st_r <= st_nxt;
			pre_r <= (clr_tmr || tick) ? '0 : pre_r + 1'b1;
			if (clr_tmr)
				ms_r <= 16'h0000;
			else if (tick)
				ms_r <= ms_r + 16'h0001;
		end
	end

	// ****************************************************************
	// outputs and telemetry
	// ****************************************************************
	logic reg_r;
	word_t dac_r;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_r <= 1'b0;
			dac_r <= `RST_VOUT_SET;
		end
		else
		begin
			reg_r <= st_nxt == ST_RUN || st_nxt == ST_OFF_WAIT;
			dac_r <= vout_set_r;
		end
	end

	vout_avg_if av ();
	assign av.smp_valid = vout_smp_valid;
	assign av.smp = vout_smp;

	vout_averager u_avg (
		.clk(clk),
		.rst(rst),
		.av(av.avg_side)
	);

	word_t rd_mux;
	always_comb
	begin
		case (cmd_rd_code)
			`CMD_OPERATION: rd_mux = {8'h00, op_r};
			`CMD_ON_OFF_CFG: rd_mux = {8'h00, cfg_r};
			`CMD_VOUT_SET: rd_mux = vout_set_r;
			`CMD_INPUT_TURN_ON_THRESHOLD: rd_mux = on_th_r;
			`CMD_INPUT_TURN_OFF_THRESHOLD: rd_mux = off_th_r;
			`CMD_TURN_ON_DELAY: rd_mux = ton_r;
			`CMD_TURN_OFF_DELAY: rd_mux = toff_r;
			`CMD_READ_VOUT: rd_mux = av.avg;
			default: rd_mux = 16'h0000;
		endcase
	end

	logic [15:0] rdata_r;
	logic rvalid_r;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
		end
		else
		begin
			rvalid_r <= cmd_rd;
			if (cmd_rd)
				rdata_r <= rd_mux;
		end
	end

	assign cmd_rdata = rdata_r;
	assign cmd_rvalid = rvalid_r;
	assign regulate = reg_r;
	assign dac_code = dac_r;
	assign vin_ok = vin_ok_r;
endmodule : converter_on_off_sequencer

// >>> design/seq_params.svh
// constants for the converter on/off sequencer
//
// Operation
// - separate turn-on and turn-off thresholds; off >= 4 V, on <= 7.75 V
// - configuration picks gating by input voltage, pin, command bit or mixes
// - after gating becomes true, wait the turn-on delay before regulating
// - after gating becomes false, regulate for the turn-off delay, then stop; input undervoltage stops at once
// - both delays are in milliseconds, range 0 to 100 ms
// - reference code in 2^-9 V units spanning 350 mV to 1650 mV
// - output voltage sampled and averaged; latest average is readable
// - operation byte bit 7 requests conversion when command gating is used
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define CMD_OPERATION 8'h01
`define CMD_ON_OFF_CFG 8'h02
`define CMD_VOUT_SET 8'h21
`define CMD_INPUT_TURN_ON_THRESHOLD 8'h35
`define CMD_INPUT_TURN_OFF_THRESHOLD 8'h36
`define CMD_TURN_ON_DELAY 8'h60
`define CMD_TURN_OFF_DELAY 8'h64
`define CMD_READ_VOUT 8'h8B

// ****************************************************************
// fields and reset values
// ****************************************************************
`define OP_ON_BIT 7
`define CFG_USE_PIN_BIT 0
`define CFG_USE_CMD_BIT 1
`define RST_OPERATION 8'h00
`define RST_ON_OFF_CFG 8'h03
`define RST_ON_TH 16'h0012
`define RST_OFF_TH 16'h0010
`define RST_VOUT_SET 16'h0200
`define RST_DELAY 16'h0000

// ****************************************************************
// limits: thresholds in 0.25 V units, reference in 2^-9 V units
// ****************************************************************
`define OFF_TH_MIN 16'h0010
`define ON_TH_MAX 16'h001F
`define DELAY_MAX_MS 16'h0064
`define DAC_MIN 16'h00B3
`define DAC_MAX 16'h034D
`define AVG_SHIFT 3

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS 20
`define MS_NS 1000000
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)

`endif

// >>> design/seq_pkg.sv
// types shared by the sequencer modules
package seq_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {ST_OFF, ST_ON_WAIT, ST_RUN, ST_OFF_WAIT} seq_state_e;
endpackage : seq_pkg

// >>> design/vout_averager.sv
// block average of output voltage samples
`timescale 1ns/1ns
`include "seq_params.svh"
module vout_averager
	import seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	vout_avg_if.avg_side av
);
	localparam int NSMP = 1 << `AVG_SHIFT;
	logic [15+`AVG_SHIFT:0] acc_r;
	logic [`AVG_SHIFT-1:0] cnt_r;
	word_t avg_r;
	wire logic last = (cnt_r == (`AVG_SHIFT)'(NSMP - 1));
	wire logic [15+`AVG_SHIFT:0] sum = acc_r + {{`AVG_SHIFT{1'b0}}, av.smp};

	// block average, not a running one: each result is independent of
	// the previous block, which keeps the adder narrow
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			acc_r <= '0;
			cnt_r <= '0;
			avg_r <= 16'h0000;
		end
		else if (av.smp_valid)
		begin
			cnt_r <= cnt_r + 1'b1;
			acc_r <= last ? '0 : sum;
			if (last)
				avg_r <= sum[15+`AVG_SHIFT:`AVG_SHIFT];
		end
	end

	assign av.avg = avg_r;
endmodule : vout_averager

// >>> design/vout_avg_if.sv
// carrier between the sequencer and the output voltage averager
`timescale 1ns/1ns
interface vout_avg_if;
	import seq_pkg::*;
	logic smp_valid;
	word_t smp;
	word_t avg;
	modport src (output smp_valid, output smp, input avg);
	modport avg_side (input smp_valid, input smp, output avg);
endinterface : vout_avg_if

// >>> verification/host_model.sv
// bus host and control pin driver facing the sequencer
`timescale 1ns/1ns
module host_model(
	input wire logic clk,
	output logic cmd_wr,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	output logic cmd_rd,
	output logic [7:0] cmd_rd_code,
	output logic control_enable_pin
);
	initial
	begin
		cmd_wr = 0;
		cmd_code = 0;
		cmd_wdata = 0;
		cmd_rd = 0;
		cmd_rd_code = 0;
		control_enable_pin = 0;
	end
	// released data is inverted so stale values are never trusted
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmd_wr = 1;
		cmd_code = c;
		cmd_wdata = d;
		@(negedge clk);
		cmd_wr = 0;
		cmd_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] c);
		@(negedge clk);
		cmd_rd = 1;
		cmd_rd_code = c;
		@(negedge clk);
		cmd_rd = 0;
		cmd_rd_code = ~c;
	endtask : rd
	task automatic pin(input logic v);
		@(negedge clk);
		control_enable_pin = v;
	endtask : pin
endmodule : host_model

// >>> verification/seq_assertions.sv
// assertion checker bound to the converter on/off sequencer
`timescale 1ns/1ns
module seq_checker(
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_rd,
	input wire logic cmd_rvalid,
	input wire logic [15:0] vin_meas,
	input wire logic regulate,
	input wire logic [15:0] dac_code,
	input wire logic vin_ok
);
	logic [15:0] ref_w_r;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ****************************************************************
	// checks
	// ****************************************************************
	// last reference written, so the dac check survives later traffic
	always_ff @(posedge clk)
		if (cmd_wr && cmd_code == 8'h21)
			ref_w_r <= cmd_wdata;
	chk_read_answer: assert property (cmd_rd |=> cmd_rvalid)
		else $error("read answer missing");
	chk_read_pulse: assert property (!cmd_rd |=> !cmd_rvalid)
		else $error("read answer without request");
	chk_dac_range: assert property (dac_code >= 16'h00B3 &&
		dac_code <= 16'h034D) else $error("reference out of range");
	chk_dac_follow: assert property (cmd_wr && cmd_code == 8'h21 &&
		cmd_wdata >= 16'h00B3 && cmd_wdata <= 16'h034D
		|=> ##[0:1] dac_code == ref_w_r) else $error("reference stale");
	chk_vin_low: assert property (vin_meas < 16'h0010 |=> !vin_ok)
		else $error("input ok below lowest turn-off");
	chk_vin_high: assert property (vin_meas >= 16'h001F |=> vin_ok)
		else $error("input not ok above highest turn-on");
	chk_lockout_stop: assert property (!vin_ok |=> !regulate)
		else $error("regulating in lockout");
	chk_start_order: assert property ($rose(vin_ok) |-> !regulate)
		else $error("regulation before gate stage");
endmodule : seq_checker
bind converter_on_off_sequencer seq_checker chk_i(.clk(clk), .rst(rst),
	.cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
	.cmd_rd(cmd_rd), .cmd_rvalid(cmd_rvalid), .vin_meas(vin_meas),
	.regulate(regulate), .dac_code(dac_code), .vin_ok(vin_ok));

// >>> verification/tb.sv
// self-checking testbench for the converter on/off sequencer
`timescale 1ns/1ns
module tb;
	logic clk, rst, wr, rd, rv, pin, sv, regulate, vok;
	logic [7:0] code, rcode;
	logic [15:0] wd, rdata, vin, smp, dac, sum;
	logic [15:0] q[$];
	int bad_count = 0, comparisons = 0, cyc = 0, n;
	logic [7:0] cw[6] = '{8'h35, 8'h36, 8'h60, 8'h64, 8'h21, 8'h21};
	logic [15:0] dw[6] = '{16'h0040, 16'h0005, 16'h00C8, 16'h0100,
		16'h0010, 16'hFFFF};
	logic [15:0] ew[6] = '{16'h001F, 16'h0010, 16'h0064, 16'h0064,
		16'h00B3, 16'h034D};
	host_model p(.clk(clk), .cmd_wr(wr), .cmd_code(code), .cmd_wdata(wd),
		.cmd_rd(rd), .cmd_rd_code(rcode), .control_enable_pin(pin));
	converter_on_off_sequencer #(.CYC_PER_MS(10)) dut(.clk(clk), .rst(rst),
		.cmd_wr(wr), .cmd_code(code), .cmd_wdata(wd), .cmd_rd(rd),
		.cmd_rd_code(rcode), .cmd_rdata(rdata), .cmd_rvalid(rv),
		.vin_meas(vin), .control_enable_pin(pin), .vout_smp_valid(sv),
		.vout_smp(smp), .regulate(regulate), .dac_code(dac),
		.vin_ok(vok));
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// ****************************************************************
	// helpers
	// ****************************************************************
	task check(input string nm, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task rdq(input logic [7:0] c, input logic [15:0] e);
		q.push_back(e);
		p.rd(c);
	endtask : rdq
	task wait_reg(input logic v, input int lo, input int hi);
		n = 0;
		while (regulate !== v && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		check("regulate_delay", 16'(n >= lo && n <= hi), 16'h0001);
	endtask : wait_reg
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	// read results are sampled mid-cycle, clear of the launching edge
	always @(negedge clk)
		if (rv === 1'b1)
			check("read_data", rdata, q.size() ? q.pop_front() : ~rdata);
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			test_done();
		end
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		rst = 1;
		vin = 0;
		sv = 0;
		smp = 0;
		n = $urandom(32'h35293e98);
		repeat (2) @(negedge clk);
		rst = 0;
		rdq(8'h02, 16'h0003);
		rdq(8'h01, 16'h0000);
		rdq(8'h35, 16'h0012);
		rdq(8'h36, 16'h0010);
		rdq(8'hEE, 16'h0000);
		check("dac_reset", dac, 16'h0200);
		$display("test reset done");
		foreach (cw[i])
		begin
			p.wr(cw[i], dw[i]);
			rdq(cw[i], ew[i]);
		end
		sum = 16'd179 + 16'($urandom % 667);
		p.wr(8'h21, sum);
		@(negedge clk);
		check("dac_set", dac, sum);
		p.wr(8'h35, 16'h0014);
		p.wr(8'h36, 16'h0011);
		p.wr(8'h8B, 16'h1234);
		rdq(8'h8B, 16'h0000);
		$display("test limits done");
		sum = 0;
		repeat (8)
		begin
			@(negedge clk);
			smp = 16'($urandom % 1024);
			sum += smp;
			sv = 1;
		end
		@(negedge clk);
		sv = 0;
		smp = ~smp;
		rdq(8'h8B, sum >> 3);
		$display("test average done");
		p.wr(8'h60, 16'h0000);
		p.wr(8'h64, 16'h0000);
		vin = 16'h0020;
		for (int m = 0; m < 4; m++)
		begin
			p.wr(8'h01, 16'h0000);
			p.pin(0);
			p.wr(8'h02, 16'(m));
			repeat (6) @(negedge clk);
			check("mode_vin", 16'(regulate), 16'(m == 0));
			p.pin(1);
			repeat (6) @(negedge clk);
			check("mode_pin", 16'(regulate), 16'(m < 2));
			p.wr(8'h01, 16'h0080);
			repeat (6) @(negedge clk);
			check("mode_cmd", 16'(regulate), 16'h0001);
		end
		vin = 16'h0008;
		wait_reg(0, 1, 3);
		check("vin_ok_low", 16'(vok), 16'h0000);
		vin = 16'h0020;
		wait_reg(1, 1, 3);
		vin = 16'h0012;
		repeat (3) @(negedge clk);
		check("vin_ok_hyst", 16'(vok), 16'h0001);
		$display("test modes done");
		p.wr(8'h60, 16'h0002);
		p.wr(8'h64, 16'h0001);
		p.wr(8'h01, 16'h0000);
		wait_reg(0, 9, 13);
		p.wr(8'h01, 16'h0080);
		wait_reg(1, 19, 23);
		vin = 16'h0008;
		wait_reg(0, 1, 2);
		$display("test delays done");
		test_done();
	end
endmodule : tb
